// file: eif_ext_irq_flags.sv
/*
  External pin event flags with level or falling-edge sensing, software
  read-then-write-0 clearing, exception-driven clearing, two priority
  registers and a masked summary interrupt, all behind an APB slave.
  Assumes pins are asynchronous and low-active, and that excDone carries
  one-cycle pulses on ref_clk from the core's exception logic.
*/
// The APB slave port was left to the implementer.
// What this block does
// - Enable bit 1 lets that pin's interrupt reach the processor.
// - Software clears a flag only after reading it as 1 then writing 0.
// - Level mode: exception handling with pin high clears the flag.
// - Edge mode: exception handling clears the flag unless a new falling edge comes in that cycle.
// - Level mode sets flag while pin low; edge mode on falling edge.
// - Writes only clear flags; ones never set; upper three bits fixed.
// - Priority bit 0 low, 1 high; both registers reset to zero.
// - Fixed bit-to-source map of both priority registers.
`timescale 1ns/1ps

module eif_ext_irq_flags (
  input wire logic ref_clk, // System clock, 125 MHz
  input wire logic rst_n, // Synchronous reset, low active
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, 1 = write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, no wait states
  output logic pslverr, // APB error, unmapped address
  input wire logic [4:0] extReqPin_n, // External request pins, low active
  input wire logic [4:0] excDone, // Core ran this pin's exception
  output logic [4:0] pinReqOut, // Per-pin request to the core
  output eif_pkg::eif_prio_t prioLevels, // Priority per source group
  output logic irqOut // Summary interrupt, level
);

  logic [4:0] sync1_ff, sync2_ff, sync3_ff, pinLvl_ff;
  logic [4:0] sense_ff, enable_ff, flags_ff, armed_ff;
  logic [4:0] stat_ff, ien_ff;
  logic [7:0] prio1_ff, prio2_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  // APB phase decode; the slave never stalls
  wire setupPh = psel & ~penable;
  wire accPh = psel & penable;
  wire wrAcc = accPh & pwrite;
  wire rdAcc = accPh & ~pwrite;
  wire wordAl = (paddr[1:0] == 2'h0);

  // Address hits
  wire hitSense = (paddr == eif_pkg::ADDR_SENSE);
  wire hitEnable = (paddr == eif_pkg::ADDR_ENABLE);
  wire hitFlags = (paddr == eif_pkg::ADDR_FLAGS);
  wire hitPrio1 = (paddr == eif_pkg::ADDR_PRIO1);
  wire hitPrio2 = (paddr == eif_pkg::ADDR_PRIO2);
  wire hitStat = (paddr == eif_pkg::ADDR_STAT);
  wire hitClr = (paddr == eif_pkg::ADDR_CLR);
  wire hitIen = (paddr == eif_pkg::ADDR_IEN);
  wire hitAny = wordAl & (hitSense | hitEnable | hitFlags | hitPrio1 |
                          hitPrio2 | hitStat | hitClr | hitIen);

  // Read selection; the clear register reads as zero
  wire [7:0] rdByte =
    hitSense ? {3'h0, sense_ff} :
    hitEnable ? {3'h0, enable_ff} :
    hitFlags ? {3'h0, flags_ff} :
    hitPrio1 ? prio1_ff :
    hitPrio2 ? prio2_ff :
    hitStat ? {3'h0, stat_ff} :
    hitIen ? {3'h0, ien_ff} : 8'h00;

  // Read data is sampled in setup so the access phase sees a stable word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata_ff <= eif_pkg::RST_RDATA;
      pslverr_ff <= 1'b0;
    end else if (setupPh) begin
      prdata_ff <= {24'h00_0000, rdByte};
      pslverr_ff <= ~hitAny;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pready = 1'b1;

  // Write strobes per register
  wire wrSense = wrAcc & hitSense & wordAl;
  wire wrEnable = wrAcc & hitEnable & wordAl;
  wire wrFlags = wrAcc & hitFlags & wordAl;
  wire wrPrio1 = wrAcc & hitPrio1 & wordAl;
  wire wrPrio2 = wrAcc & hitPrio2 & wordAl;
  wire wrClr = wrAcc & hitClr & wordAl;
  wire wrIen = wrAcc & hitIen & wordAl;
  wire rdFlags = rdAcc & hitFlags & wordAl;

  // Accept a new level only once stages two and three agree
  wire [4:0] agree = ~(sync2_ff ^ sync3_ff);
  wire [4:0] nxt_pinLvl = (agree & sync2_ff) | (~agree & pinLvl_ff);
  wire [4:0] fallEv = pinLvl_ff & ~nxt_pinLvl;

  // Three-stage pin synchroniser; idle level is high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_ff <= eif_pkg::RST_SYNC;
      sync2_ff <= eif_pkg::RST_SYNC;
      sync3_ff <= eif_pkg::RST_SYNC;
      pinLvl_ff <= eif_pkg::RST_SYNC;
    end else begin
      sync1_ff <= extReqPin_n;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pinLvl_ff <= nxt_pinLvl;
    end
  end

  // Flag setting per sense mode
  wire [4:0] setEv = (~sense_ff & ~pinLvl_ff) | (sense_ff & fallEv);

  // Exception clears: level mode needs the pin back high
  wire [4:0] hwClr = excDone & (sense_ff | pinLvl_ff);

  // Software clear needs a prior read of 1; a written 1 is ignored
  wire [4:0] swClr = {5{wrFlags}} & armed_ff & ~pwdata[4:0];

  // A set in the same cycle as a clear keeps the flag
  wire [4:0] nxt_flags = setEv | (flags_ff & ~(hwClr | swClr));

  // Read arms bits seen as 1; any write to the flags disarms
  wire [4:0] nxt_armed = wrFlags ? 5'h00 :
                         rdFlags ? (armed_ff | prdata_ff[4:0]) & nxt_flags :
                         armed_ff & nxt_flags;

  // Sticky status on every new flag, set beats the clear write
  wire [4:0] newEv = setEv & ~flags_ff;
  wire [4:0] clrMask = wrClr ? pwdata[4:0] : 5'h00;
  wire [4:0] nxt_stat = newEv | (stat_ff & ~clrMask);

  // Flag, arming and status state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_ff <= eif_pkg::RST_PIN5;
      armed_ff <= eif_pkg::RST_PIN5;
      stat_ff <= eif_pkg::RST_PIN5;
    end else begin
      flags_ff <= nxt_flags;
      armed_ff <= nxt_armed;
      stat_ff <= nxt_stat;
    end
  end

  // Plain control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sense_ff <= eif_pkg::RST_PIN5;
      enable_ff <= eif_pkg::RST_PIN5;
      ien_ff <= eif_pkg::RST_PIN5;
      prio1_ff <= eif_pkg::RST_PRIO;
      prio2_ff <= eif_pkg::RST_PRIO;
    end else begin
      if (wrSense) sense_ff <= pwdata[4:0];
      if (wrEnable) enable_ff <= pwdata[4:0];
      if (wrIen) ien_ff <= pwdata[4:0];
      if (wrPrio1) prio1_ff <= pwdata[7:0];
      if (wrPrio2) prio2_ff <= pwdata[7:0];
    end
  end

  // Requests to the core gated by enables
  assign pinReqOut = flags_ff & enable_ff;

  // Summary interrupt from enabled status bits
  assign irqOut = |(stat_ff & ien_ff);

  // Source-group priority map, 1 = high level
  assign prioLevels.irq0 = prio1_ff[7];
  assign prioLevels.irq1 = prio1_ff[6];
  assign prioLevels.irq23 = prio1_ff[5];
  assign prioLevels.irq4 = prio1_ff[4];
  assign prioLevels.watchdogUnit = prio1_ff[3];
  assign prioLevels.tmr0 = prio1_ff[2];
  assign prioLevels.tmr1 = prio1_ff[1];
  assign prioLevels.tmr2 = prio1_ff[0];
  assign prioLevels.tmr3 = prio2_ff[eif_pkg::B2_TMR3];
  assign prioLevels.tmr4 = prio2_ff[eif_pkg::B2_TMR4];
  assign prioLevels.serialCommUnit = prio2_ff[eif_pkg::B2_SER];
  assign prioLevels.converter = prio2_ff[eif_pkg::B2_ADC];

  // Checks on the flag machinery and the register map

  property p_req_gate;
    @(posedge ref_clk) disable iff (!rst_n)
    pinReqOut == (flags_ff & enable_ff);
  endproperty
  a_req_gate: assert property (p_req_gate)
    else $error("pin request not equal to flag and enable");

  property p_req_enable;
    @(posedge ref_clk) disable iff (!rst_n)
    (enable_ff == 5'h00) |-> (pinReqOut == 5'h00);
  endproperty
  a_req_enable: assert property (p_req_enable)
    else $error("request went out with enables clear");

  property p_clear_cause;
    @(posedge ref_clk) disable iff (!rst_n)
    ((~flags_ff & $past(flags_ff)) &
     ~($past(excDone) | ($past(armed_ff) & {5{$past(wrFlags)}}))) == 5'h00;
  endproperty
  a_clear_cause: assert property (p_clear_cause)
    else $error("flag cleared without read-then-write or exception");

  property p_sw_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    (wrFlags && armed_ff[1] && !pwdata[1] && !setEv[1]) |=>
    !flags_ff[1];
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("flag 1 kept after read of 1 and write of 0");

  property p_level_exc;
    @(posedge ref_clk) disable iff (!rst_n)
    (excDone[0] && !sense_ff[0] && pinLvl_ff[0]) |=> !flags_ff[0];
  endproperty
  a_level_exc: assert property (p_level_exc)
    else $error("level flag 0 survived exception with pin high");

  property p_edge_exc;
    @(posedge ref_clk) disable iff (!rst_n)
    (excDone[4] && sense_ff[4] && !fallEv[4]) |=> !flags_ff[4];
  endproperty
  a_edge_exc: assert property (p_edge_exc)
    else $error("edge flag 4 survived exception");

  property p_level_set;
    @(posedge ref_clk) disable iff (!rst_n)
    (!sense_ff[1] && !pinLvl_ff[1]) |=> flags_ff[1];
  endproperty
  a_level_set: assert property (p_level_set)
    else $error("level flag 1 not set while pin low");

  property p_edge_set;
    @(posedge ref_clk) disable iff (!rst_n)
    (sense_ff[4] && (sync2_ff[4] == sync3_ff[4]) && !sync3_ff[4] &&
     pinLvl_ff[4]) |=> flags_ff[4];
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("edge flag 4 not set on falling pin");

  property p_no_write_set;
    @(posedge ref_clk) disable iff (!rst_n)
    ((flags_ff & ~$past(flags_ff)) & ~$past(setEv)) == 5'h00;
  endproperty
  a_no_write_set: assert property (p_no_write_set)
    else $error("flag rose without a pin event");

  property p_upper_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (setupPh && hitFlags) |=> (prdata[7:5] == 3'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper flag bits read nonzero");

  property p_prio_reset;
    @(posedge ref_clk) disable iff (!rst_n)
    $past(!rst_n) |-> (prio1_ff == 8'h00 && prio2_ff == 8'h00);
  endproperty
  a_prio_reset: assert property (p_prio_reset)
    else $error("priority registers not zero after reset");

  property p_prio_map;
    @(posedge ref_clk) disable iff (!rst_n)
    (wrPrio2 && pwdata[7] && pwdata[3]) |=>
    (prioLevels.tmr3 && prioLevels.serialCommUnit);
  endproperty
  a_prio_map: assert property (p_prio_map)
    else $error("second priority bits 7 and 3 not mapped");

  property p_irq_out;
    @(posedge ref_clk) disable iff (!rst_n)
    (newEv[0] && ien_ff[0] && !wrIen) |=> irqOut;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("summary interrupt missing after enabled event");

  // Status, filter and bus-side checks; a clear write must not eat a new event

  property p_stat_set;
    @(posedge ref_clk) disable iff (!rst_n)
    (newEv != 5'h00) |=> ((stat_ff & $past(newEv)) == $past(newEv));
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("status bit not set by a new flag");

  property p_stat_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    wrClr |=>
    ((stat_ff & $past(clrMask) & ~$past(newEv)) == 5'h00);
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status bit kept after clear write");

  property p_level_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    (excDone[0] && !sense_ff[0] && !pinLvl_ff[0]) |=> flags_ff[0];
  endproperty
  a_level_keep: assert property (p_level_keep)
    else $error("level flag 0 lost on exception with pin low");

  property p_filter;
    @(posedge ref_clk) disable iff (!rst_n)
    (sync2_ff[0] != sync3_ff[0]) |=> $stable(pinLvl_ff[0]);
  endproperty
  a_filter: assert property (p_filter)
    else $error("pin level moved before stages agreed");

  property p_armed_drop;
    @(posedge ref_clk) disable iff (!rst_n)
    wrFlags |=> (armed_ff == 5'h00);
  endproperty
  a_armed_drop: assert property (p_armed_drop)
    else $error("flag arming kept after a flag write");

  property p_prio_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    (!wrPrio1 && !wrPrio2) |=>
    ($stable(prio1_ff) && $stable(prio2_ff));
  endproperty
  a_prio_hold: assert property (p_prio_hold)
    else $error("priority register changed without a write");

  property p_slverr;
    @(posedge ref_clk) disable iff (!rst_n)
    (setupPh && !hitAny) |=> pslverr;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("no bus error on unmapped address");

  property p_rd_stable;
    @(posedge ref_clk) disable iff (!rst_n)
    accPh |=> $stable(prdata);
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("read data moved at the access edge");

endmodule

// file: eif_pkg.sv
/*
  Constants, register map and carrier types of the external pin interrupt
  flag and priority block.
  Assumes a 32-bit APB master and a core that pulses one bit per pin when
  it runs that pin's exception handling.
*/
package eif_pkg;

  // Pin count and flag field
  localparam int unsigned NPIN = 5;
  localparam int unsigned FLAG_MSB = 4;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_SENSE = 8'hf4;
  localparam logic [7:0] IDX_ENABLE = 8'hf5;
  localparam logic [7:0] IDX_FLAGS = 8'hf6;
  localparam logic [7:0] IDX_PRIO1 = 8'hf8;
  localparam logic [7:0] IDX_PRIO2 = 8'hf9;
  localparam logic [7:0] IDX_STAT = 8'hfa;
  localparam logic [7:0] IDX_CLR = 8'hfb;
  localparam logic [7:0] IDX_IEN = 8'hfc;

  // Byte addresses on the 12-bit APB address
  localparam logic [11:0] ADDR_SENSE = {2'h0, IDX_SENSE, 2'h0};
  localparam logic [11:0] ADDR_ENABLE = {2'h0, IDX_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_FLAGS = {2'h0, IDX_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_PRIO1 = {2'h0, IDX_PRIO1, 2'h0};
  localparam logic [11:0] ADDR_PRIO2 = {2'h0, IDX_PRIO2, 2'h0};
  localparam logic [11:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
  localparam logic [11:0] ADDR_CLR = {2'h0, IDX_CLR, 2'h0};
  localparam logic [11:0] ADDR_IEN = {2'h0, IDX_IEN, 2'h0};

  // Values after reset
  localparam logic [4:0] RST_PIN5 = 5'h00;
  localparam logic [4:0] RST_SYNC = 5'h1f;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // Bit positions in the second priority register
  localparam int unsigned B2_TMR3 = 7;
  localparam int unsigned B2_TMR4 = 6;
  localparam int unsigned B2_SER = 3;
  localparam int unsigned B2_ADC = 1;

  // Priority level per source group, 1 = high
  typedef struct packed {
    logic irq0;
    logic irq1;
    logic irq23;
    logic irq4;
    logic watchdogUnit;
    logic tmr0;
    logic tmr1;
    logic tmr2;
    logic tmr3;
    logic tmr4;
    logic serialCommUnit;
    logic converter;
  } eif_prio_t;

endpackage

// file: eif_core_model.sv
/*
  Core exception model: serves the lowest pending pin request after a
  fixed latency and pulses that pin's handled bit for one cycle.
  Assumes pinReq is a level from the block, sampled on ref_clk.
*/
`timescale 1ns/1ps

module eif_core_model #(
  parameter int LAT = 3 // Wait count; handling comes LAT+1 cycles after the request
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Synchronous reset, low active
  input wire logic [4:0] pinReq, // Pin requests from the block
  output logic [4:0] excDone // Handled pulse per pin
);
  logic [7:0] waitCnt_ff;

  // Lowest pin wins; the latency stands in for instruction completion
  always_ff @(posedge ref_clk) begin
    excDone <= 5'h00;
    if (!rst_n || pinReq == 5'h00) begin
      waitCnt_ff <= 8'h00;
    end else if (waitCnt_ff == 8'(LAT)) begin
      waitCnt_ff <= 8'h00;
      excDone <= pinReq & (~pinReq + 5'h01);
    end else begin
      waitCnt_ff <= waitCnt_ff + 8'h01;
    end
  end
endmodule

// file: eif_tb.sv
/*
  Self-checking bench for the pin flag block: APB tasks, pin stimulus
  and the core model answering requests.
  Assumes the package map and the zero-wait APB slave of the block.
*/
`timescale 1ns/1ps

module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irqOut, err;
  logic [4:0] extReqPin_n = 5'h1f;
  logic [4:0] excDone, pinReqOut;
  eif_pkg::eif_prio_t prioLevels;
  int num_errors = 0;
  int check_count = 0;

  // 125 MHz system clock
  always #4 ref_clk = ~ref_clk;

  eif_ext_irq_flags u_eif_ext_irq_flags (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extReqPin_n(extReqPin_n), .excDone(excDone),
    .pinReqOut(pinReqOut), .prioLevels(prioLevels), .irqOut(irqOut));
  eif_core_model #(.LAT(3)) u_eif_core_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .pinReq(pinReqOut), .excDone(excDone));

  // One APB transfer; returns just after the access edge has landed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask

  // Pins pass a three-stage filter, so allow six cycles to settle
  task automatic pins(input logic [4:0] v);
    @(posedge ref_clk);
    extReqPin_n <= v;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic finish_test;
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the roughly 180 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end

  // Main sequence
  initial begin
    logic [7:0] p1 [2];
    logic [7:0] p2 [2];
    logic seen;
    p1 = '{8'ha5, 8'h5a};
    p2 = '{8'hca, 8'h35};
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(eif_pkg::ADDR_FLAGS, 32'h0, "flags");
    rdchk(eif_pkg::ADDR_PRIO1, 32'h0, "prio1");
    rdchk(eif_pkg::ADDR_PRIO2, 32'h0, "prio2");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, eif_pkg::ADDR_PRIO1, {24'h0, p1[i]});
      apb(1'b1, eif_pkg::ADDR_PRIO2, {24'h0, p2[i]});
      rdchk(eif_pkg::ADDR_PRIO1, {24'h0, p1[i]}, "prio1");
      rdchk(eif_pkg::ADDR_PRIO2, {24'h0, p2[i]}, "prio2");
      chk("prioLevels", {20'h0, p1[i], p2[i][7], p2[i][6], p2[i][3], p2[i][1]},
        {20'h0, prioLevels});
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // Level mode, pins masked: software clear needs a prior read
    apb(1'b1, eif_pkg::ADDR_SENSE, 32'h0);
    apb(1'b1, eif_pkg::ADDR_ENABLE, 32'h0);
    apb(1'b1, eif_pkg::ADDR_IEN, 32'h0);
    pins(5'h1d);
    chk("pinReqOut", 32'h0, {27'h0, pinReqOut});
    chk("irqOut", 32'h0, {31'h0, irqOut});
    pins(5'h1f);
    apb(1'b1, eif_pkg::ADDR_FLAGS, 32'h0);
    rdchk(eif_pkg::ADDR_FLAGS, 32'h02, "flags");
    apb(1'b1, eif_pkg::ADDR_FLAGS, 32'hff);
    rdchk(eif_pkg::ADDR_FLAGS, 32'h02, "flags");
    apb(1'b1, eif_pkg::ADDR_FLAGS, 32'h0);
    rdchk(eif_pkg::ADDR_FLAGS, 32'h0, "flags");
    // Sticky status, enable mask and clear
    rdchk(eif_pkg::ADDR_STAT, 32'h02, "status");
    apb(1'b1, eif_pkg::ADDR_IEN, 32'h02);
    chk("irqOut", 32'h1, {31'h0, irqOut});
    apb(1'b1, eif_pkg::ADDR_IEN, 32'h0);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    apb(1'b1, eif_pkg::ADDR_CLR, 32'h02);
    rdchk(eif_pkg::ADDR_STAT, 32'h0, "status");
    apb(1'b1, eif_pkg::ADDR_IEN, 32'h1f);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    // Level mode: handling with pin low keeps the flag, pin high clears
    apb(1'b1, eif_pkg::ADDR_ENABLE, 32'h01);
    pins(5'h1e);
    repeat (8) @(posedge ref_clk);
    #1;
    chk("pinReqOut", 32'h01, {27'h0, pinReqOut});
    pins(5'h1f);
    repeat (6) @(posedge ref_clk);
    #1;
    chk("pinReqOut", 32'h0, {27'h0, pinReqOut});
    rdchk(eif_pkg::ADDR_FLAGS, 32'h0, "flags");
    // Edge mode: falling edge sets once, handling clears with pin low
    apb(1'b1, eif_pkg::ADDR_SENSE, 32'h1f);
    apb(1'b1, eif_pkg::ADDR_ENABLE, 32'h1f);
    seen = 1'b0;
    @(posedge ref_clk);
    extReqPin_n <= 5'h0f;
    for (int k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      #1;
      if (pinReqOut[4] === 1'b1) seen = 1'b1;
    end
    chk("edge request", 32'h1, {31'h0, seen});
    chk("pinReqOut", 32'h0, {27'h0, pinReqOut});
    pins(5'h1f);
    rdchk(eif_pkg::ADDR_FLAGS, 32'h0, "flags");
    rdchk(eif_pkg::ADDR_STAT, 32'h11, "status");
    chk("irqOut", 32'h1, {31'h0, irqOut});
    apb(1'b1, eif_pkg::ADDR_CLR, 32'h1f);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    finish_test();
  end
endmodule
